// ---- common/int_entry_regs.vh ----
// constants for the interrupt entry and exit controller
// assumes a core sequencer that strobes once per machine cycle
`ifndef INT_ENTRY_REGS_VH
`define INT_ENTRY_REGS_VH

// vector layout in code memory
`define VEC_BASE      16'h0003
`define VEC_STEP      16'h0008
`define VEC_LAST      16'h00FB
`define VEC_STEP_LOG  3

// sources: 0 and 2 are the external pins, the rest are peripherals
`define NUM_SRC       8
`define SRC_IDX_W     3
`define EXT0_SRC      3'h0
`define EXT1_SRC      3'h2

// peripheral sources whose flag is cleared on acknowledge
`define AUTO_CLR_MASK 8'h0A

// call and return sequences, in machine cycles or bytes
`define CALL_CYCLES   2'h2
`define POP_BYTES     2'h2

// call sequencer states
`define CALL_IDLE     2'h0
`define CALL_LO       2'h1
`define CALL_HI       2'h2

// return sequencer states
`define EXIT_IDLE     2'h0
`define EXIT_HI       2'h1
`define EXIT_LO       2'h2
`define EXIT_LOAD     2'h3

`endif

// ---- rtl/interrupt_entry_control.v ----
// interrupt entry and exit control for an 8-bit core
// assumes phase_stb pulses one clk cycle per machine cycle at state five
// phase two, and all core-side inputs are on clk; only ext_pin_b is async
//
// How it works
// - source i vectors to base 0003 plus eight times i, never past 00FB.
// - every flag is sampled at each machine cycle strobe and polled next.
// - a sampled, enabled, unblocked flag forces a far_subroutine_call to its vector.
// - no call while an equal or higher level service is in progress.
// - no call unless the polling cycle is the instruction's last cycle.
// - exit or enable/priority writes block, so one more instruction runs.
// - a denied request is not remembered; only current flags are polled.
// - some flags clear on acknowledge, others are left to software.
// - interrupt_exit_instr clears the level, pops two bytes, reloads pc.
// - plain_subroutine_exit is not seen here, so the level stays active.
// - external flags are set at state_five_second_phase, sampled at the next strobe, polled after.
// - the call takes two machine cycles after the polling cycle.
// - a blocking instruction adds at most one cycle plus one instruction.
// - a lone request is answered after more than three, under nine cycles.
`timescale 1ns/1ps
`include "int_entry_regs.vh"

module interrupt_entry_control (
	input  wire        clk,
	input  wire        rst_b,
	input  wire        clk_en,
	input  wire        phase_stb,
	input  wire        last_cycle,
	input  wire        blocking_instr,
	input  wire        exit_instr,
	input  wire        global_en,
	input  wire [7:0]  src_en,
	input  wire [7:0]  src_prio,
	input  wire [1:0]  ext_pin_b,
	input  wire [1:0]  ext_edge,
	input  wire [5:0]  periph_req,
	input  wire [15:0] pc_in,
	input  wire [7:0]  stack_byte,
	output wire        call_busy,
	output wire        push_stb,
	output reg  [7:0]  push_byte,
	output reg         vec_load,
	output reg  [15:0] call_vector,
	output wire        pop_stb,
	output reg         pc_load,
	output reg  [15:0] resume_pc,
	output reg  [1:0]  in_progress,
	output reg  [7:0]  ack_clear
);

////////////////////////////////////////////////////////////////////////////
// external pin synchronisers and request flags

reg  [1:0]  pin_meta_reg;
reg  [1:0]  pin_sync_reg;
reg  [1:0]  pin_prev_reg;
reg  [1:0]  edge_seen_reg;
reg  [1:0]  ext_flag_reg;
wire [1:0]  pin_fall;
wire [1:0]  ext_ack;
wire [7:0]  flags;

assign pin_fall = pin_prev_reg & ~pin_sync_reg;

always @(posedge clk) begin
	if (!rst_b) begin
		pin_meta_reg <= 2'h3;
		pin_sync_reg <= 2'h3;
		pin_prev_reg <= 2'h3;
	end else if (clk_en) begin
		pin_meta_reg <= ext_pin_b;
		pin_sync_reg <= pin_meta_reg;
		pin_prev_reg <= pin_sync_reg;
	end
end

// a falling edge between strobes is held until the next flag update
genvar g;
generate
	for (g = 0; g < 2; g = g + 1) begin : ext_gen
		always @(posedge clk) begin
			if (!rst_b) begin
				edge_seen_reg[g] <= 1'b0;
				ext_flag_reg[g]  <= 1'b0;
			end else if (clk_en) begin
				if (phase_stb) begin
					edge_seen_reg[g] <= 1'b0;
				end else if (pin_fall[g]) begin
					edge_seen_reg[g] <= 1'b1;
				end
				if (phase_stb) begin
					// flags only change at state_five_second_phase
					if (ext_edge[g]) begin
						// set wins over the acknowledge clear
						if (edge_seen_reg[g] || pin_fall[g]) begin
							ext_flag_reg[g] <= 1'b1;
						end else if (ext_ack[g]) begin
							ext_flag_reg[g] <= 1'b0;
						end
					end else begin
						// level mode follows the pin, no latching
						ext_flag_reg[g] <= ~pin_sync_reg[g];
					end
				end else if (ext_ack[g] && ext_edge[g]) begin
					ext_flag_reg[g] <= 1'b0;
				end
			end
		end
	end
endgenerate

assign flags = {periph_req[5:1], ext_flag_reg[1], periph_req[0],
	ext_flag_reg[0]};

////////////////////////////////////////////////////////////////////////////
// sampling and polling

reg  [7:0]  sampled_reg;
reg  [1:0]  call_state_reg;
reg  [1:0]  call_state_next;
reg  [1:0]  exit_state_reg;
reg  [1:0]  exit_state_next;
wire [7:0]  pend;
wire [7:0]  pend_hi;
wire [7:0]  pend_lo;
wire        block_hi;
wire        block_lo;
wire        may_poll;
reg         win;
reg  [2:0]  win_idx;
reg         win_hi;
integer     i;

// flags captured at one strobe are judged at the next
always @(posedge clk) begin
	if (!rst_b) begin
		sampled_reg <= 8'h00;
	end else if (clk_en && phase_stb) begin
		sampled_reg <= flags;
	end
end

// only what is set now counts; a denied request leaves no trace
assign pend = sampled_reg & src_en & {8{global_en}};
assign pend_hi = pend & src_prio;
assign pend_lo = pend & ~src_prio;

// a running high level blocks all, a running low level blocks low ones
assign block_hi = in_progress[1];
assign block_lo = in_progress[1] | in_progress[0];

// the call may only start at the end of a finished ordinary instruction
assign may_poll = phase_stb & last_cycle & ~blocking_instr
	& (call_state_reg == `CALL_IDLE) & (exit_state_reg == `EXIT_IDLE);

// fixed order: high level first, then lowest source number
always @* begin
	win = 1'b0;
	win_idx = 3'h0;
	win_hi = 1'b0;
	for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
		if (pend_lo[i] && !block_lo) begin
			win = 1'b1;
			win_idx = i[2:0];
			win_hi = 1'b0;
		end
	end
	for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
		if (pend_hi[i] && !block_hi) begin
			win = 1'b1;
			win_idx = i[2:0];
			win_hi = 1'b1;
		end
	end
end

wire grant;
assign grant = may_poll & win;

assign ext_ack[0] = grant & (win_idx == `EXT0_SRC);
assign ext_ack[1] = grant & (win_idx == `EXT1_SRC);

////////////////////////////////////////////////////////////////////////////
// hardware call: two machine cycles, pc low byte then high byte

reg  [15:0] save_pc_reg;
wire [15:0] vec_addr;

// vectors stay inside 0003..003B, well below the 00FB ceiling
assign vec_addr = `VEC_BASE + ({13'h0000, win_idx} << `VEC_STEP_LOG);

always @* begin
	call_state_next = call_state_reg;
	case (call_state_reg)
	`CALL_IDLE: begin
		if (grant) begin
			call_state_next = `CALL_LO;
		end
	end
	`CALL_LO: begin
		if (phase_stb) begin
			call_state_next = `CALL_HI;
		end
	end
	`CALL_HI: begin
		if (phase_stb) begin
			call_state_next = `CALL_IDLE;
		end
	end
	default: begin
		call_state_next = `CALL_IDLE;
	end
	endcase
end

assign call_busy = (call_state_reg != `CALL_IDLE);
// gated so a frozen block never pushes the same byte twice
assign push_stb = clk_en & phase_stb & call_busy;

always @(posedge clk) begin
	if (!rst_b) begin
		call_state_reg <= `CALL_IDLE;
		save_pc_reg    <= 16'h0000;
		push_byte      <= 8'h00;
		call_vector    <= 16'h0000;
		vec_load       <= 1'b0;
		ack_clear      <= 8'h00;
	end else if (clk_en) begin
		call_state_reg <= call_state_next;
		vec_load <= 1'b0;
		ack_clear <= 8'h00;
		if (grant) begin
			save_pc_reg <= pc_in;
			push_byte   <= pc_in[7:0];
			call_vector <= vec_addr;
			// peripheral flags on the auto list get a clear pulse
			ack_clear <= `AUTO_CLR_MASK & (8'h01 << win_idx);
		end
		if (call_state_reg == `CALL_LO && phase_stb) begin
			push_byte <= save_pc_reg[15:8];
		end
		if (call_state_reg == `CALL_HI && phase_stb) begin
			vec_load <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// level bookkeeping and return sequence

always @(posedge clk) begin
	if (!rst_b) begin
		in_progress <= 2'h0;
	end else if (clk_en) begin
		if (grant) begin
			if (win_hi) begin
				in_progress[1] <= 1'b1;
			end else begin
				in_progress[0] <= 1'b1;
			end
		end else if (exit_instr && exit_state_reg == `EXIT_IDLE) begin
			// only the exit instruction leaves a level; a plain return
			// never reaches this block, so the level stays marked
			if (in_progress[1]) begin
				in_progress[1] <= 1'b0;
			end else begin
				in_progress[0] <= 1'b0;
			end
		end
	end
end

always @* begin
	exit_state_next = exit_state_reg;
	case (exit_state_reg)
	`EXIT_IDLE: begin
		if (exit_instr) begin
			exit_state_next = `EXIT_HI;
		end
	end
	`EXIT_HI: begin
		exit_state_next = `EXIT_LO;
	end
	`EXIT_LO: begin
		exit_state_next = `EXIT_LOAD;
	end
	`EXIT_LOAD: begin
		exit_state_next = `EXIT_IDLE;
	end
	default: begin
		exit_state_next = `EXIT_IDLE;
	end
	endcase
end

// the stack top is the high byte, pushed last by the call;
// gated so a frozen block never pops the stack more than twice
assign pop_stb = clk_en & ((exit_state_reg == `EXIT_HI)
	| (exit_state_reg == `EXIT_LO));

always @(posedge clk) begin
	if (!rst_b) begin
		exit_state_reg <= `EXIT_IDLE;
		resume_pc      <= 16'h0000;
		pc_load        <= 1'b0;
	end else if (clk_en) begin
		exit_state_reg <= exit_state_next;
		pc_load <= 1'b0;
		if (exit_state_reg == `EXIT_HI) begin
			resume_pc[15:8] <= stack_byte;
		end
		if (exit_state_reg == `EXIT_LO) begin
			resume_pc[7:0] <= stack_byte;
			pc_load <= 1'b1;
		end
	end
end

endmodule

// ---- test/core_seq_model.sv ----
// core sequencer stand-in: machine cycle strobe and the stack
// assumes pushes and pops never overlap
`timescale 1ns/1ps
module core_seq_model (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       push_stb,
	input wire logic [7:0] push_byte,
	input wire logic       pop_stb,
	output logic           phase_stb,
	output logic     [7:0] stack_byte
);
	logic [7:0] mem [0:15];
	logic [3:0] sp_reg;
	logic [1:0] div_reg;
	// four clk per machine cycle keeps the run short
	assign phase_stb = div_reg == 2'h3;
	// outside a pop the byte is scrambled so a stray sample shows
	assign stack_byte = pop_stb ? mem[sp_reg] : ~mem[sp_reg];
	always @(posedge clk) begin
		if (!rst_b) begin
			div_reg <= 2'h0;
			sp_reg <= 4'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
			if (push_stb) begin
				mem[sp_reg + 4'h1] <= push_byte;
				sp_reg <= sp_reg + 4'h1;
			end else if (pop_stb)
				sp_reg <= sp_reg - 4'h1;
		end
	end
endmodule

// ---- test/int_entry_chk.sv ----
// checker for the interrupt entry controller, bound to every instance
// assumes the shared constants header and a single clk domain
`timescale 1ns/1ps
`include "int_entry_regs.vh"
module int_entry_chk (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        phase_stb,
	input wire logic        last_cycle,
	input wire logic        blocking_instr,
	input wire logic        exit_instr,
	input wire logic        call_busy,
	input wire logic        push_stb,
	input wire logic        vec_load,
	input wire logic [15:0] call_vector,
	input wire logic        pop_stb,
	input wire logic        pc_load,
	input wire logic [1:0]  in_progress,
	input wire logic [7:0]  ack_clear
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_vec_place: assert property (
		vec_load |-> call_vector[2:0] == 3'h3 && call_vector <= `VEC_LAST)
		else $error("vector off table");
	a_grant_cause: assert property (
		$rose(call_busy) |-> $past(phase_stb && last_cycle && !blocking_instr))
		else $error("call without a legal poll");
	a_level_block: assert property (
		$rose(call_busy) |-> !$past(in_progress[1]))
		else $error("call during high level service");
	a_push_gate: assert property (
		push_stb |-> call_busy && phase_stb)
		else $error("push outside a call");
	a_call_end: assert property (
		$fell(call_busy) |-> vec_load && $past(push_stb))
		else $error("call ended without vector load");
	a_ack_mask: assert property (
		(ack_clear & ~`AUTO_CLR_MASK) == 8'h00)
		else $error("clear on a software cleared source");
	a_exit_pop: assert property (
		$rose(pop_stb) |-> $past(exit_instr) ##1 pop_stb ##1 pc_load && !pop_stb)
		else $error("bad pop sequence");
	a_exit_clear: assert property (
		exit_instr && !phase_stb && !pop_stb && !pc_load && in_progress[1]
		|=> !in_progress[1])
		else $error("exit left high level active");
	cover property ($rose(call_busy));
	cover property (pc_load);
	cover property (ack_clear != 8'h00);
endmodule
bind interrupt_entry_control int_entry_chk chk (.clk, .rst_b, .phase_stb,
	.last_cycle, .blocking_instr, .exit_instr, .call_busy, .push_stb,
	.vec_load, .call_vector, .pop_stb, .pc_load, .in_progress, .ack_clear);

// ---- test/interrupt_entry_control_bench.sv ----
// self-checking bench for the interrupt entry controller
// assumes core_seq_model supplies the machine cycle strobe and stack
`timescale 1ns/1ps
`include "int_entry_regs.vh"
module interrupt_entry_control_bench;
	logic        clk = 0, rst_b = 0, last_cycle = 1, blocking_instr = 0;
	logic        exit_instr = 0, global_en = 1;
	logic [7:0]  src_en = 8'hff, src_prio = 8'h00, push_byte, stack_byte;
	logic [7:0]  ack_clear, ack_seen;
	logic [1:0]  ext_pin_b = 2'h3, ext_edge = 2'h2, in_progress;
	logic [5:0]  periph_req = 6'h00;
	logic [15:0] pc_in = 16'h0000, pcv, call_vector, resume_pc;
	logic        phase_stb, call_busy, push_stb, vec_load, pop_stb, pc_load;
	logic [16:0] exp_q[$];
	logic [16:0] got;
	integer      errors = 0, num_checks = 0, seed = 32'h1d2c, k, s;
	always #50 clk = ~clk;
	interrupt_entry_control uut (.clk, .rst_b, .clk_en(1'b1), .phase_stb,
		.last_cycle, .blocking_instr, .exit_instr, .global_en, .src_en,
		.src_prio, .ext_pin_b, .ext_edge, .periph_req, .pc_in, .stack_byte,
		.call_busy, .push_stb, .push_byte, .vec_load, .call_vector, .pop_stb,
		.pc_load, .resume_pc, .in_progress, .ack_clear);
	core_seq_model core (.clk, .rst_b, .push_stb, .push_byte, .pop_stb,
		.phase_stb, .stack_byte);
	task check(input logic [16:0] seen, want, input string what);
		num_checks++;
		if (seen !== want) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, want, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk) if (vec_load || pc_load) begin
		got = {pc_load, pc_load ? resume_pc : call_vector};
		if (exp_q.size() == 0)
			check(1, 0, "unexpected");
		else
			check(got, exp_q.pop_front(), "transfer");
	end
	////////////////////////////////////////////////////////////////////////
	task wait_call(input logic [15:0] vec, input logic [7:0] ack);
		exp_q.push_back({1'b0, vec});
		ack_seen = 8'h00;
		for (k = 0; k < 36 && !vec_load; k++) begin
			@(posedge clk);
			ack_seen = ack_seen | ack_clear;
		end
		check(k < 36, 1, "latency");
		check(ack_seen, ack, "ack_clear");
		if (k >= 36)
			report_and_stop;
		@(posedge clk);
	endtask
	task do_exit;
		repeat (8) @(posedge clk);
		exp_q.push_back({1'b1, pcv});
		exit_instr <= 1;
		@(posedge clk) exit_instr <= 0;
		repeat (4) @(posedge clk);
	endtask
	task no_call(input integer n);
		repeat (n) begin
			@(posedge clk);
			check(call_busy, 0, "call_busy");
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1;
		repeat (4) @(posedge clk);
		for (s = 1; s < 8; s++) if (s != 2) begin
			pcv = $random(seed);
			pc_in <= pcv;
			periph_req <= 6'h01 << (s == 1 ? 0 : s - 2);
			wait_call(16'h0003 + 16'h0008 * s, `AUTO_CLR_MASK & (8'h01 << s));
			periph_req <= 6'h00;
			do_exit;
		end
		// low level left active by a plain return: same level stays out
		periph_req <= 6'h02;
		wait_call(16'h001B, 8'h08);
		periph_req <= 6'h04;
		no_call(24);
		src_prio <= 8'h10;
		wait_call(16'h0023, 8'h00);
		periph_req <= 6'h00;
		do_exit;
		do_exit;
		periph_req <= 6'h08;
		last_cycle <= 0;
		no_call(16);
		last_cycle <= 1;
		blocking_instr <= 1;
		no_call(16);
		// drop the flag while still blocked so no sample of it survives
		periph_req <= 6'h00;
		no_call(8);
		blocking_instr <= 0;
		no_call(16);
		global_en <= 0;
		periph_req <= 6'h08;
		no_call(16);
		periph_req <= 6'h00;
		no_call(8);
		global_en <= 1;
		periph_req <= 6'h0a;
		src_prio <= 8'h20;
		wait_call(16'h002B, 8'h00);
		// sources 3 and 4 now tie at the low level
		periph_req <= 6'h06;
		do_exit;
		wait_call(16'h001B, 8'h08);
		periph_req <= 6'h00;
		do_exit;
		for (s = 0; s < 2; s++) begin
			ext_pin_b <= ~(2'h1 << s);
			if (s == 1)
				repeat (8) @(posedge clk) ext_pin_b <= 2'h3;
			wait_call(16'h0003 + 16'h0010 * s, 8'h00);
			ext_pin_b <= 2'h3;
			do_exit;
		end
		check(exp_q.size(), 0, "queue");
		report_and_stop;
	end
endmodule
